//--- omid_core.sv
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module omid_core (
  input  wire logic                         mclk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic                         ce_i,
  input  wire logic                         instr_valid_i,
  input  wire logic [omid_pkg::INSTR_W-1:0] instr_i,
  input  wire logic                         next_two_word_i,
  input  wire logic [7:0]                   file_rdata_i,
  output logic                              instr_ready_o,
  output logic      [omid_pkg::ADDR_W-1:0]  file_addr_o,
  output logic                              file_re_o,
  output logic                              file_we_o,
  output logic      [7:0]                   file_wdata_o,
  output logic      [7:0]                   acc_o,
  output logic      [7:0]                   product_high_o,
  output logic      [7:0]                   product_low_o,
  output logic                              neg_o,
  output logic                              zero_o,
  output logic                              skip_o,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [omid_pkg::WB_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [omid_pkg::WB_DW-1:0]   wb_dat_i,
  output logic      [omid_pkg::WB_DW-1:0]   wb_dat_o,
  output logic                              wb_ack_o
);
  import omid_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  omid_state_t       state;
  omid_state_t       next_state;
  omid_op_t          op_q;
  omid_op_t          dec_op;
  logic [1:0]        q;
  logic [15:0]       ir;
  logic [7:0]        opnd;
  logic [7:0]        res;
  logic [15:0]       prod_res;
  logic              skip_res;
  logic              two_word;
  logic              ext_en;
  logic [BSR_W-1:0]  bank_select_register;
  logic [ADDR_W-1:0] idx_base;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire is_inc = (instr_i[15:10] == OPC_INCSNZ);
  wire is_orf = (instr_i[15:10] == OPC_ORF);
  wire is_orl = (instr_i[15:8] == OPC_ORL);
  wire is_mull = (instr_i[15:8] == OPC_MULL);
  wire is_mulf = (instr_i[15:9] == OPC_MULF);
  // anything else belongs to other execution units and is a nop here
  assign dec_op = is_inc  ? OP_INCSNZ :
                  is_orf  ? OP_ORF :
                  is_orl  ? OP_ORL :
                  is_mull ? OP_MULL :
                  is_mulf ? OP_MULF : OP_NONE;

  wire dbit = ir[BIT_DEST];
  wire abit = ir[BIT_ACCESS];
  wire uses_file = (op_q == OP_INCSNZ) || (op_q == OP_ORF) || (op_q == OP_MULF);
  wire is_or = (op_q == OP_ORL) || (op_q == OP_ORF);
  wire is_mul = (op_q == OP_MULL) || (op_q == OP_MULF);
  // multiply-file carries an access bit but no destination bit
  wire to_file = ((op_q == OP_INCSNZ) || (op_q == OP_ORF)) && dbit;
  wire to_acc = ((op_q == OP_INCSNZ) || (op_q == OP_ORF)) && !dbit || (op_q == OP_ORL);
  wire take = ce_i && (q == PH_Q1) && (state == ST_EXEC) && instr_valid_i;
  wire commit = ce_i && (q == PH_Q4);

  // ---------------------------------------------------------------
  // datapath submodules
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] eff_addr;
  logic [7:0]        alu_res;
  logic [15:0]       alu_prod;
  logic              alu_skip;
  wire [7:0]         alu_opnd = uses_file ? file_rdata_i : opnd; // file ops take Q3 read data

  omid_addr u_addr (
    .f_i        (ir[7:0]),
    .access_i   (abit),
    .ext_en_i   (ext_en),
    .bsr_i      (bank_select_register),
    .idx_base_i (idx_base),
    .addr_o     (eff_addr),
    .indexed_o  ()
  );

  omid_alu u_alu (
    .op_i      (op_q),
    .acc_i     (acc_o),
    .opnd_i    (alu_opnd),
    .result_o  (alu_res),
    .product_o (alu_prod),
    .skip_o    (alu_skip)
  );

  // ---------------------------------------------------------------
  // quarter-phase counter and skip sequencing
  // ---------------------------------------------------------------
  always_comb begin
    case (state)
      ST_EXEC:  next_state = skip_res ? ST_SKIP1 : ST_EXEC;
      ST_SKIP1: next_state = two_word ? ST_SKIP2 : ST_EXEC;
      ST_SKIP2: next_state = ST_EXEC;
      default:  next_state = ST_EXEC;
    endcase
  end

  // the state only moves on the last quarter, so a skip spans whole cycles
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      q <= PH_Q1;
      state <= ST_EXEC;
      instr_ready_o <= 1'b1;
      skip_o <= 1'b0;
    end else if (ce_i) begin
      q <= q + PH_STEP;
      if (q == PH_Q4) begin
        state <= next_state;
        instr_ready_o <= (next_state == ST_EXEC);
        skip_o <= (next_state != ST_EXEC);
      end
    end
  end

  // the next instruction's width is known when the skip is decided
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      two_word <= 1'b0;
    end else if (commit && (state == ST_EXEC)) begin
      two_word <= next_two_word_i;
    end
  end

  // ---------------------------------------------------------------
  // Q1 decode, Q2 read, Q3 process, Q4 write
  // ---------------------------------------------------------------
  // skip cycles take no instruction, so op_q is none throughout them
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ir <= RST_INSTR;
      op_q <= OP_NONE;
    end else if (take) begin
      ir <= instr_i;
      op_q <= dec_op;
    end else if (commit) begin
      op_q <= OP_NONE;
    end
  end

  // address is driven for the Q3 read, file data sampled at the end of Q3
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      file_addr_o <= RST_IDX;
      file_re_o <= 1'b0;
      opnd <= RST_BYTE;
    end else if (ce_i) begin
      if (q == PH_Q2) begin
        file_addr_o <= eff_addr;
        file_re_o <= uses_file;
        opnd <= ir[7:0];
      end else if (q == PH_Q3) begin
        file_re_o <= 1'b0;
        if (uses_file) begin
          opnd <= file_rdata_i;
        end
      end
    end
  end

  // processed result is held for the Q4 write-back
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      res <= RST_BYTE;
      prod_res <= {RST_BYTE, RST_BYTE};
      skip_res <= 1'b0;
      file_we_o <= 1'b0;
      file_wdata_o <= RST_BYTE;
    end else if (ce_i) begin
      if (q == PH_Q3) begin
        res <= alu_res;
        prod_res <= alu_prod;
        skip_res <= alu_skip;
        file_we_o <= to_file;
        file_wdata_o <= alu_res;
      end else if (q == PH_Q4) begin
        skip_res <= 1'b0;
        file_we_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire bus_wr = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  wire wr_acc = bus_wr && (wb_adr_i == REG_ACC);
  wire wr_product_low = bus_wr && (wb_adr_i == REG_PRODUCT_LOW);
  wire wr_product_high = bus_wr && (wb_adr_i == REG_PRODUCT_HIGH);
  wire wr_stat = bus_wr && (wb_adr_i == REG_STATUS);
  wire wr_bsr = bus_wr && (wb_adr_i == REG_BSR);
  wire wr_ctrl = bus_wr && (wb_adr_i == REG_CTRL);
  wire wr_idx = bus_wr && (wb_adr_i == REG_IDXBASE);
  wire [7:0] stat_rd = {5'h00, skip_o, neg_o, zero_o};
  // unmapped offsets still ack and read zero
  wire [7:0] rd_byte = (wb_adr_i == REG_ACC)     ? acc_o :
                       (wb_adr_i == REG_PRODUCT_LOW)   ? product_low_o :
                       (wb_adr_i == REG_PRODUCT_HIGH)   ? product_high_o :
                       (wb_adr_i == REG_STATUS)  ? stat_rd :
                       (wb_adr_i == REG_BSR)     ? {4'h0, bank_select_register} :
                       (wb_adr_i == REG_CTRL)    ? {7'h00, ext_en} : RST_BYTE;
  wire [WB_DW-1:0] rd_word = (wb_adr_i == REG_IDXBASE) ? {20'h00000, idx_base}
                                                      : {24'h000000, rd_byte};

  // one wait state; ack drops the cycle after it was given
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= {WB_DW{1'b0}};
    end else if (ce_i) begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // architectural registers; a Q4 write-back wins over a bus write
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      acc_o <= RST_BYTE;
      neg_o <= 1'b0;
      zero_o <= 1'b0;
    end else if (ce_i) begin
      if (commit && to_acc) begin
        acc_o <= res;
      end else if (wr_acc) begin
        acc_o <= wb_dat_i[7:0];
      end
      if (commit && is_or) begin
        neg_o <= res[BIT_SIGN];
        zero_o <= (res == RST_BYTE);
      end else if (wr_stat) begin
        neg_o <= wb_dat_i[STAT_NEG];
        zero_o <= wb_dat_i[STAT_ZERO];
      end
    end
  end

  // product pair lands at the end of Q4; flags are left alone
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      product_high_o <= RST_BYTE;
      product_low_o <= RST_BYTE;
    end else if (ce_i) begin
      if (commit && is_mul) begin
        product_high_o <= prod_res[15:8];
        product_low_o <= prod_res[7:0];
      end else begin
        if (wr_product_high) product_high_o <= wb_dat_i[7:0];
        if (wr_product_low) product_low_o <= wb_dat_i[7:0];
      end
    end
  end

  // configuration written only by software
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      bank_select_register <= RST_BSR;
      ext_en <= 1'b0;
      idx_base <= RST_IDX;
    end else if (ce_i) begin
      if (wr_bsr) bank_select_register <= wb_dat_i[BSR_W-1:0];
      if (wr_ctrl) ext_en <= wb_dat_i[CTRL_EXT];
      if (wr_idx) idx_base <= wb_dat_i[ADDR_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  inc_dest_a: assert property ((commit && op_q == OP_INCSNZ && !dbit)
    |=> acc_o == 8'($past(opnd) + INC_STEP)) else $error("increment not in acc");
  skip_enter_a: assert property ((commit && op_q == OP_INCSNZ && res != RST_BYTE)
    |=> state == ST_SKIP1 && !instr_ready_o) else $error("nonzero did not skip");
  skip_len_a: assert property ((commit && state == ST_SKIP1 && two_word)
    |=> state == ST_SKIP2 ##4 state == ST_EXEC [*1]) else $error("two-word skip length");
  skip_nop_a: assert property ((state != ST_EXEC)
    |-> op_q == OP_NONE && !file_we_o) else $error("work during skip");
  bank_sel_a: assert property ((ce_i && q == PH_Q2 && abit && uses_file)
    |=> file_addr_o == {bank_select_register, ir[7:0]}) else $error("banked address");
  idx_mode_a: assert property ((ce_i && q == PH_Q2 && ext_en && !abit
    && ir[7:0] <= INDEX_LIMIT) |=> file_addr_o ==
    ADDR_W'($past(idx_base) + {4'h0, $past(ir[7:0])})) else $error("indexed address");
  or_lit_a: assert property ((commit && op_q == OP_ORL)
    |=> acc_o == $past(res) && $past(res) == ($past(ir[7:0]) | $past(acc_o, 2)))
    else $error("or literal result");
  or_file_a: assert property ((commit && op_q == OP_ORF && dbit)
    |-> file_we_o && file_wdata_o == res) else $error("or file write");
  mul_lit_a: assert property ((commit && op_q == OP_MULL)
    |=> {product_high_o, product_low_o} == {8'h00, $past(ir[7:0])} * {8'h00, $past(acc_o)})
    else $error("product pair");
  mul_keep_a: assert property ((commit && op_q == OP_MULF)
    |-> !file_we_o ##1 $stable(acc_o)) else $error("multiply changed operand");
  mul_flags_a: assert property ((commit && is_mul)
    |=> $stable(neg_o) && $stable(zero_o)) else $error("multiply touched flags");
  or_flags_a: assert property ((commit && is_or)
    |=> !$past(to_acc) || (neg_o == acc_o[BIT_SIGN] && zero_o == (acc_o == RST_BYTE)))
    else $error("or flags");

  skip_one_c: cover property (commit && state == ST_SKIP1 && !two_word);
  skip_two_c: cover property (commit && state == ST_SKIP2);
  mul_done_c: cover property (commit && op_q == OP_MULF);
  or_zero_c: cover property (commit && is_or && res == RST_BYTE);

endmodule

//--- omid_pkg.sv
package omid_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned BSR_W = 4;
  localparam int unsigned WB_AW = 8;
  localparam int unsigned WB_DW = 32;

  // ---------------------------------------------------------------
  // quarter-phases of one instruction cycle
  // ---------------------------------------------------------------
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;

  // ---------------------------------------------------------------
  // opcode fields and instruction bit positions
  // ---------------------------------------------------------------
  localparam logic [5:0] OPC_INCSNZ = 6'h12;
  localparam logic [5:0] OPC_ORF = 6'h04;
  localparam logic [7:0] OPC_ORL = 8'h09;
  localparam logic [7:0] OPC_MULL = 8'h0d;
  localparam logic [6:0] OPC_MULF = 7'h01;
  localparam int unsigned BIT_DEST = 9;
  localparam int unsigned BIT_ACCESS = 8;
  localparam int unsigned BIT_SIGN = 7;

  // ---------------------------------------------------------------
  // file addressing
  // ---------------------------------------------------------------
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [7:0] INC_STEP = 8'h01;

  // ---------------------------------------------------------------
  // register map (byte offsets) and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_ACC = 8'h00;
  localparam logic [7:0] REG_PRODUCT_LOW = 8'h04;
  localparam logic [7:0] REG_PRODUCT_HIGH = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_BSR = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  localparam logic [7:0] REG_IDXBASE = 8'h18;
  localparam int unsigned STAT_ZERO = 0;
  localparam int unsigned STAT_NEG = 1;
  localparam int unsigned STAT_SKIP = 2;
  localparam int unsigned CTRL_EXT = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_BSR = 4'h0;
  localparam logic [11:0] RST_IDX = 12'h000;
  localparam logic [15:0] RST_INSTR = 16'h0000;

  typedef enum logic [2:0] {
    ST_EXEC  = 3'h1,
    ST_SKIP1 = 3'h2,
    ST_SKIP2 = 3'h4
  } omid_state_t;

  typedef enum logic [5:0] {
    OP_NONE   = 6'h01,
    OP_INCSNZ = 6'h02,
    OP_ORL    = 6'h04,
    OP_ORF    = 6'h08,
    OP_MULL   = 6'h10,
    OP_MULF   = 6'h20
  } omid_op_t;

endpackage

//--- omid_addr.sv
`timescale 1ns/1ps
module omid_addr (
  input  wire logic [7:0]                     f_i,
  input  wire logic                           access_i,
  input  wire logic                           ext_en_i,
  input  wire logic [omid_pkg::BSR_W-1:0]     bsr_i,
  input  wire logic [omid_pkg::ADDR_W-1:0]    idx_base_i,
  output logic      [omid_pkg::ADDR_W-1:0]    addr_o,
  output logic                                indexed_o
);
  import omid_pkg::*;

  // ---------------------------------------------------------------
  // address resolution
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] banked_addr;
  logic [ADDR_W-1:0] access_addr;
  logic [ADDR_W-1:0] index_addr;

  // a=1 picks the bank from the bank select register, a=0 the access bank
  assign banked_addr = {bsr_i, f_i};
  assign access_addr = (f_i < ACCESS_SPLIT) ? {ACCESS_LO_BANK, f_i}
                                            : {ACCESS_HI_BANK, f_i};
  // indexed offset only covers the low access half; upper half stays sfr space
  assign indexed_o = ext_en_i && !access_i && (f_i <= INDEX_LIMIT);
  assign index_addr = ADDR_W'(idx_base_i + {4'h0, f_i});
  assign addr_o = access_i ? banked_addr : (indexed_o ? index_addr : access_addr);

endmodule

//--- omid_alu.sv
`timescale 1ns/1ps
module omid_alu (
  input  wire omid_pkg::omid_op_t        op_i,
  input  wire logic [7:0]                acc_i,
  input  wire logic [7:0]                opnd_i,
  output logic      [7:0]                result_o,
  output logic      [15:0]               product_o,
  output logic                           skip_o
);
  import omid_pkg::*;

  // ---------------------------------------------------------------
  // combinational execution
  // ---------------------------------------------------------------
  logic [7:0] inc_val;
  logic [7:0] or_val;

  assign inc_val = 8'(opnd_i + INC_STEP);
  assign or_val = acc_i | opnd_i;
  // unsigned 8x8, zero-extended so no bits are lost
  assign product_o = {8'h00, acc_i} * {8'h00, opnd_i};
  assign result_o = (op_i == OP_INCSNZ) ? inc_val : or_val;
  assign skip_o = (op_i == OP_INCSNZ) && (inc_val != RST_BYTE);

endmodule

//--- omid_core_bench.sv
`timescale 1ns/1ps
module omid_core_bench;
  import omid_pkg::*;
  // ---------------------------------------------------------------
  // stimulus, response and model state
  // ---------------------------------------------------------------
  logic        mclk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, instr_valid_i = 1'b0;
  logic        next_two_word_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic [7:0]  wb_adr_i = 8'h00, file_rdata_i, file_wdata_o, acc_o, product_high_o;
  logic [7:0]  product_low_o, macc = 8'h00, mph = 8'h00, mpl = 8'h00, rnd = 8'h18;
  logic [3:0]  wb_sel_i = 4'h1, mbsr = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, bq[$];
  logic        instr_ready_o, file_re_o, file_we_o, neg_o, zero_o, skip_o, wb_ack_o;
  logic [11:0] file_addr_o, midx = 12'h000;
  logic [19:0] fq[$];
  logic [7:0]  fmem[4096], mm[4096];
  logic        mn = 1'b0, mz = 1'b0, mext = 1'b0, b2b = 1'b0;
  logic [1:0]  ph = 2'h0;
  logic [27:0] sq[$];
  int          num_errors = 0, check_count = 0, pend = 1;

  always #25 mclk_i = ~mclk_i;
  // file storage answers combinationally; writes land on the pulse
  assign file_rdata_i = fmem[file_addr_o];
  always @(posedge mclk_i) if (file_we_o === 1'b1) fmem[file_addr_o] <= file_wdata_o;
  // quarter of each edge; ce_i stays high so every edge counts
  always @(posedge mclk_i) ph <= sys_rst_i ? 2'h0 : ph + 2'h1;

  omid_core omid_core_i (
    .mclk_i, .sys_rst_i, .ce_i, .instr_valid_i, .instr_i, .next_two_word_i, .file_rdata_i,
    .instr_ready_o, .file_addr_o, .file_re_o, .file_we_o, .file_wdata_o, .acc_o,
    .product_high_o, .product_low_o, .neg_o, .zero_o, .skip_o, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    $display("CHECK FAILED wait expected done seen timeout");
    stop_test();
  endtask

  // one classic cycle; read data is left to the monitor via bq
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    input logic [31:0] exp);
    int n;
    if (!we) bq.push_back(exp);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, d};
    for (n = 0; n < 20; n++) begin
      @(posedge mclk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (n == 20) hang();
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge mclk_i);
    b2b = 1'b0;
  endtask

  // file address the model expects for f and the access bit
  function automatic logic [11:0] fa(input logic [7:0] f, input logic a);
    if (a) return {mbsr, f};
    if (mext && f <= INDEX_LIMIT) return midx + {4'h0, f};
    return {(f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, f};
  endfunction

  // ---------------------------------------------------------------
  // instruction driver: models the op and notes the outcome
  // ---------------------------------------------------------------
  task automatic issue(input logic [15:0] ins, input logic two);
    logic [11:0] ad;
    logic [7:0]  fv, r;
    logic        sk, inc, orr;
    int          n;
    ad = fa(ins[7:0], ins[8]);
    fv = mm[ad];
    sk = 1'b0;
    r = 8'h00;
    inc = ins[15:10] == OPC_INCSNZ;
    orr = ins[15:10] == OPC_ORF || ins[15:8] == OPC_ORL;
    {instr_i, next_two_word_i, instr_valid_i} <= {ins, two, 1'b1};
    for (n = 1; n < 20; n++) begin
      @(posedge mclk_i);
      if (ph == 2'h0 && instr_ready_o === 1'b1) break;
    end
    if (n == 20) hang();
    if (b2b) chk("issue gap", n, pend);
    instr_valid_i <= 1'b0;
    pend = 1;
    if (inc) begin
      r = fv + INC_STEP;
      sk = r != 8'h00;
      pend = sk ? (two ? 9 : 5) : 1;
    end else if (ins[15:10] == OPC_ORF) r = macc | fv;
    else if (ins[15:8] == OPC_ORL) r = macc | ins[7:0];
    else {mph, mpl} = macc * (ins[15:8] == OPC_MULL ? ins[7:0] : fv);
    if (orr) {mn, mz} = {r[7], r == 8'h00};
    if ((inc || orr) && ins[9] && ins[15:8] != OPC_ORL) begin
      mm[ad] = r;
      fq.push_back({ad, r});
    end else if (inc || orr) macc = r;
    repeat (3) @(posedge mclk_i);
    sq.push_back({macc, mph, mpl, mn, mz, sk});
    b2b = 1'b1;
  endtask

  // monitor: takes the oldest note whenever its result shows
  always @(posedge mclk_i) begin
    if (file_we_o === 1'b1) chk("file write", {file_addr_o, file_wdata_o},
      fq.size() > 0 ? fq.pop_front() : 20'hfffff);
    if (skip_o === 1'b1) chk("nop cycle", {file_re_o, file_we_o}, 2'b00);
    if (ph == 2'h0 && sq.size() > 0) chk("state", {acc_o, product_high_o, product_low_o,
      neg_o, zero_o, skip_o}, sq.pop_front());
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && bq.size() > 0) chk("bus read", wb_dat_o,
      bq.pop_front());
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] dir[12] = '{16'h0900, 16'h0d00, 16'h0980, 16'h0d00, 16'h097f, 16'h1310,
                             16'h4910, 16'h4b10, 16'h4b10, 16'h0dff, 16'h4b10, 16'h0310};
    logic [7:0]  f;
    int          i;
    for (i = 0; i < 4096; i++) begin
      rnd = lfsr(rnd);
      fmem[i] = rnd;
      mm[i] = rnd;
    end
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    chk("reset", {acc_o, product_high_o, product_low_o, neg_o, zero_o, skip_o,
      instr_ready_o}, 32'h1);
    wb(1'b1, 8'hfc, 32'h5a, 32'h0);
    wb(1'b0, 8'hfc, 32'h0, 32'h0);
    wb(1'b1, REG_ACC, 32'h0, 32'h0);
    // zero and sign corners, flags kept by multiplies, skip lengths
    for (i = 0; i < 12; i++) issue(dir[i], i == 8);
    wb(1'b0, REG_STATUS, 32'h0, {30'h0, mn, mz});
    for (i = 0; i < 240; i++) begin
      if (i % 8 == 0) begin
        rnd = lfsr(rnd);
        {mbsr, mext, midx, macc} = {rnd[3:0], rnd[4], rnd, rnd[7:4], rnd};
        wb(1'b1, REG_BSR, {28'h0, mbsr}, 32'h0);
        wb(1'b1, REG_CTRL, {31'h0, mext}, 32'h0);
        wb(1'b1, REG_IDXBASE, {20'h0, midx}, 32'h0);
        wb(1'b1, REG_ACC, {24'h0, macc}, 32'h0);
        wb(1'b0, REG_IDXBASE, 32'h0, {20'h0, midx});
      end
      rnd = lfsr(rnd);
      f = rnd;
      rnd = lfsr(rnd);
      case (i % 5)
        0: issue({OPC_INCSNZ, i[3:2], f}, rnd[0]);
        1: issue({OPC_ORF, i[3:2], f}, rnd[0]);
        2: issue({OPC_ORL, f}, rnd[0]);
        3: issue({OPC_MULL, f}, rnd[0]);
        default: issue({OPC_MULF, i[2], f}, rnd[0]);
      endcase
    end
    // let the last note reach its phase before the queues are judged
    repeat (2) @(posedge mclk_i);
    chk("queues left", sq.size() + fq.size() + bq.size(), 32'h0);
    stop_test();
  end
endmodule
